// >>> rtl/cise_exec.sv
// Instruction subset executor with APB register access.
//
// Operation
// RULE_01 - Sleep entry clears the watchdog count and its prescaler.
// RULE_02 - Sleep entry clears the sleep entry flag, sets the expiry flag and leaves other flags alone.
// RULE_03 - After sleep entry the core halts with its oscillator stopped.
// RULE_04 - Return pops the stack, loads the stack head into the program counter and keeps all flags.
// RULE_05 - Return takes two instruction cycles.
// RULE_06 - Literal minus accumulator writes the accumulator and updates carry, nibble link and zero.
// RULE_07 - Rotate right moves the register through carry and updates only carry.
// RULE_08 - Register minus accumulator updates carry, nibble link and zero.
// RULE_09 - Destination bit 0 sends the result to the accumulator, 1 back to the register.
// RULE_10 - Nibble exchange swaps the two halves of the register and keeps all flags.
// RULE_11 - Register xor accumulator routes by destination and updates only zero.
// RULE_12 - Literal xor accumulator writes the accumulator and updates only zero.
// RULE_13 - Subtraction sets carry on no borrow out of bit 7 and nibble link on no borrow out of bit 3.
// RULE_14 - Zero is set exactly when the 8-bit result is zero.
// RULE_15 - Every instruction except return completes in one instruction cycle.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module cise_exec #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             osc_run,
  output logic             busy
);

  localparam int SPW = $clog2(STACK_DEPTH);

  typedef struct packed {
    cise_pkg::cise_state_type state;
    logic [15:0]              instr;
    logic [7:0]               accum;
    logic [7:0]               operand;
    logic [7:0]               result;
    logic [4:0]               flags;
    logic [12:0]              pc;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [SPW-1:0]           sp;
    logic [7:0]               wdog;
    logic [7:0]               presc;
    logic                     reg_wr;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     err;
    logic                     run;
    logic                     exec;
  } cise_regs_type;

  cise_regs_type q;
  cise_regs_type d;

  // ==========================================================================
  // Subtraction helper
  // ==========================================================================
  function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    // RULE_13 no borrow flags
    sub_flags = {~full[8], ~low[4], full[7:0]};
  endfunction

  // ==========================================================================
  // Bus and stack helpers
  // ==========================================================================
  // Picks out the access phase of a write to one register offset.
  function automatic logic write_hit(input logic       sel,
                                     input logic       en,
                                     input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] off);
    write_hit = sel && en && wr && (addr == off);
  endfunction

  // Index of the stack head, one below the next free slot. Pushes and pops wrap
  // at the stack depth, so an overflow silently overwrites the oldest entry.
  function automatic logic [SPW-1:0] head_index(input logic [SPW-1:0] ptr);
    head_index = ptr - SPW'(1);
  endfunction

  logic setup_phase;
  logic access_phase;
  logic [9:0] sub_lit;
  logic [9:0] sub_reg;
  cise_pkg::cise_op_type op;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign op           = cise_pkg::cise_op_type'(q.instr[cise_pkg::INSTR_OP_LSB +: 4]);
  assign sub_lit      = sub_flags(q.instr[cise_pkg::INSTR_LIT_LSB +: 8], q.accum);
  assign sub_reg      = sub_flags(q.operand, q.accum);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [7:0] res;
    logic       upd_z;
    logic       to_acc;
    res    = 8'h00;
    upd_z  = 1'b0;
    to_acc = 1'b0;
    d = q;
    d.reg_wr = 1'b0;
    case (q.state)
      cise_pkg::ST_EXEC: begin
        d.state = cise_pkg::ST_IDLE;
        case (op)
          cise_pkg::OP_SLEEP: begin
            // RULE_01 clear watchdog
            d.wdog  = cise_pkg::WDOG_CLEAR;
            d.presc = cise_pkg::PRESC_CLEAR;
            // RULE_02 sleep flags
            d.flags[cise_pkg::ST_SLEEP_POS]  = 1'b0;
            d.flags[cise_pkg::ST_EXPIRY_POS] = 1'b1;
            // RULE_03 halt core
            d.state = cise_pkg::ST_HALT;
          end
          cise_pkg::OP_RETURN: begin
            // RULE_05 second cycle
            d.state = cise_pkg::ST_SECOND;
          end
          cise_pkg::OP_LIT_SUB: begin
            // RULE_06 literal subtract
            res    = sub_lit[7:0];
            to_acc = 1'b1;
            upd_z  = 1'b1;
            d.flags[cise_pkg::ST_LINK_POS]   = sub_lit[9];
            d.flags[cise_pkg::ST_NIBBLE_POS] = sub_lit[8];
          end
          cise_pkg::OP_ROT_R: begin
            // RULE_07 rotate through carry
            res    = {q.flags[cise_pkg::ST_LINK_POS], q.operand[7:1]};
            to_acc = !q.instr[cise_pkg::INSTR_DEST_POS];
            d.flags[cise_pkg::ST_LINK_POS] = q.operand[0];
          end
          cise_pkg::OP_REG_SUB: begin
            // RULE_08 register subtract
            res    = sub_reg[7:0];
            to_acc = !q.instr[cise_pkg::INSTR_DEST_POS];
            upd_z  = 1'b1;
            d.flags[cise_pkg::ST_LINK_POS]   = sub_reg[9];
            d.flags[cise_pkg::ST_NIBBLE_POS] = sub_reg[8];
          end
          cise_pkg::OP_NIB_X: begin
            // RULE_10 swap nibbles
            res    = {q.operand[3:0], q.operand[7:4]};
            to_acc = !q.instr[cise_pkg::INSTR_DEST_POS];
          end
          cise_pkg::OP_REG_XOR: begin
            // RULE_11 register xor
            res    = q.accum ^ q.operand;
            to_acc = !q.instr[cise_pkg::INSTR_DEST_POS];
            upd_z  = 1'b1;
          end
          cise_pkg::OP_LIT_XOR: begin
            // RULE_12 literal xor
            res    = q.accum ^ q.instr[cise_pkg::INSTR_LIT_LSB +: 8];
            to_acc = 1'b1;
            upd_z  = 1'b1;
          end
          default: begin
            d.state = cise_pkg::ST_IDLE;
          end
        endcase
        // RULE_14 zero flag
        if (upd_z) begin
          d.flags[cise_pkg::ST_ZERO_POS] = (res == 8'h00);
        end
        if (op != cise_pkg::OP_SLEEP && op != cise_pkg::OP_RETURN) begin
          d.result = res;
          // RULE_09 destination select
          if (to_acc) begin
            d.accum = res;
          end else begin
            d.operand = res;
            d.reg_wr  = 1'b1;
          end
        end
      end
      cise_pkg::ST_SECOND: begin
        // RULE_04 pop stack head
        d.pc    = q.stack[head_index(q.sp)];
        d.sp    = head_index(q.sp);
        d.state = cise_pkg::ST_IDLE;
      end
      cise_pkg::ST_HALT: begin
        if (write_hit(psel, penable, pwrite, paddr, cise_pkg::CTRL_OFF) && pwdata[cise_pkg::CTRL_WAKE_POS]) begin
          d.state = cise_pkg::ST_IDLE;
        end
      end
      default: begin
        // RULE_15 single cycle start
        if (write_hit(psel, penable, pwrite, paddr, cise_pkg::CTRL_OFF) && pwdata[cise_pkg::CTRL_GO_POS]) begin
          d.state = cise_pkg::ST_EXEC;
        end
      end
    endcase
    // ==========================================================================
    // Watchdog
    // ==========================================================================
    // The prescaler divides the clock and the count steps each time it wraps;
    // both stand still in ST_EXEC and while the core is halted, but keep counting in the second cycle of a return.
    if (q.state != cise_pkg::ST_EXEC && q.state != cise_pkg::ST_HALT) begin
      d.presc = q.presc + 8'h01;
      if (&q.presc) begin
        d.wdog = q.wdog + 8'h01;
      end
    end

    // Oscillator and busy outputs follow the next state so that both leave flops.
    d.run  = (d.state != cise_pkg::ST_HALT);
    d.exec = (d.state == cise_pkg::ST_EXEC) || (d.state == cise_pkg::ST_SECOND);

    // ==========================================================================
    // Register bus writes
    // ==========================================================================
    // Zero wait states; data registers take writes only while the core is idle so
    // that a running instruction never sees its operands move under it.
    d.ready = setup_phase;
    d.err   = 1'b0;
    d.rdata = 32'h0000_0000;
    if (access_phase && pwrite && q.state == cise_pkg::ST_IDLE) begin
      if (paddr == cise_pkg::INSTR_OFF) begin
        d.instr = pwdata[15:0];
      end else if (paddr == cise_pkg::ACCUM_OFF) begin
        d.accum = pwdata[7:0];
      end else if (paddr == cise_pkg::STATUS_OFF) begin
        d.flags = pwdata[4:0];
      end else if (paddr == cise_pkg::REG_OFF) begin
        d.operand = pwdata[7:0];
      end else if (paddr == cise_pkg::STACK_OFF) begin
        d.stack[q.sp] = pwdata[12:0];
        d.sp          = q.sp + SPW'(1);
      end
    end

    // ==========================================================================
    // Register bus reads
    // ==========================================================================
    // Read data is captured in the setup cycle and stands through the access cycle.
    if (setup_phase) begin
      if (paddr == cise_pkg::CTRL_OFF) begin
        d.rdata = 32'h0000_0000;
      end else if (paddr == cise_pkg::INSTR_OFF) begin
        d.rdata = {16'h0000, q.instr};
      end else if (paddr == cise_pkg::ACCUM_OFF) begin
        d.rdata = {24'h000000, q.accum};
      end else if (paddr == cise_pkg::STATUS_OFF) begin
        d.rdata = {22'h000000, q.state == cise_pkg::ST_HALT, q.state != cise_pkg::ST_IDLE, 3'h0, q.flags};
      end else if (paddr == cise_pkg::REG_OFF) begin
        d.rdata = {24'h000000, q.operand};
      end else if (paddr == cise_pkg::PC_OFF) begin
        d.rdata = {19'h00000, q.pc};
      end else if (paddr == cise_pkg::STACK_OFF) begin
        d.rdata = {19'h00000, q.stack[head_index(q.sp)]};
      end else if (paddr == cise_pkg::WDOG_OFF) begin
        d.rdata = {16'h0000, q.presc, q.wdog};
      end else if (paddr == cise_pkg::RESULT_OFF) begin
        d.rdata = {23'h000000, q.reg_wr, q.result};
      end else begin
        d.err = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.state <= cise_pkg::ST_IDLE;
      q.accum <= cise_pkg::ACCUM_RST;
      q.flags <= cise_pkg::FLAGS_RST;
      q.pc    <= cise_pkg::PC_RST;
      q.run   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata  = q.rdata;
  assign pready  = q.ready;
  assign pslverr = q.err;
  assign osc_run = q.run;
  assign busy    = q.exec;

endmodule

// >>> rtl/cise_pkg.sv
// Package with constants, opcodes and register map for the instruction subset executor.
package cise_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  // ==========================================================================
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] INSTR_OFF    = 8'h04;
  localparam logic [7:0] ACCUM_OFF    = 8'h08;
  localparam logic [7:0] STATUS_OFF   = 8'h0c;
  localparam logic [7:0] REG_OFF      = 8'h10;
  localparam logic [7:0] PC_OFF       = 8'h14;
  localparam logic [7:0] STACK_OFF    = 8'h18;
  localparam logic [7:0] WDOG_OFF     = 8'h1c;
  localparam logic [7:0] RESULT_OFF   = 8'h20;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ST_LINK_POS    = 0;
  localparam int ST_NIBBLE_POS  = 1;
  localparam int ST_ZERO_POS    = 2;
  localparam int ST_SLEEP_POS   = 3;
  localparam int ST_EXPIRY_POS  = 4;
  localparam int CTRL_GO_POS    = 0;
  localparam int CTRL_WAKE_POS  = 1;
  localparam int INSTR_LIT_LSB  = 0;
  localparam int INSTR_DEST_POS = 8;
  localparam int INSTR_OP_LSB   = 12;
  localparam int STATUS_BUSY_POS  = 8;
  localparam int STATUS_HALT_POS  = 9;

  // ==========================================================================
  // Reset values and sleep clear values
  // ==========================================================================
  localparam logic [7:0]  ACCUM_RST  = 8'h00;
  localparam logic [4:0]  FLAGS_RST  = 5'h18;
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [7:0]  WDOG_CLEAR = 8'h00;
  localparam logic [7:0]  PRESC_CLEAR = 8'h00;

  // ==========================================================================
  // Timing counts in instruction cycles
  // ==========================================================================
  localparam logic [1:0] RETURN_CYCLES = 2'h2;
  localparam logic [1:0] SINGLE_CYCLES = 2'h1;

  typedef enum logic [3:0] {
    OP_SLEEP    = 4'b0000,
    OP_RETURN   = 4'b0001,
    OP_LIT_SUB  = 4'b0010,
    OP_ROT_R    = 4'b0011,
    OP_REG_SUB  = 4'b0100,
    OP_NIB_X    = 4'b0101,
    OP_REG_XOR  = 4'b0110,
    OP_LIT_XOR  = 4'b0111
  } cise_op_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_SECOND = 2'b10,
    ST_HALT   = 2'b11
  } cise_state_type;

endpackage

// >>> verification/cise_exec_asserts.sv
// Port timing checker for the instruction subset executor.
`timescale 1ns/1ps
module cise_exec_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_run,
  input wire logic        busy
);
  logic [3:0] op_q;
  logic       wr_ok;
  logic       go_w;
  logic       wake_w;
  // ==========================================================
  // Helpers
  // ==========================================================
  // Writes count only while the core is idle, as the slave refuses them otherwise.
  assign wr_ok = psel && penable && pwrite && pready && !busy && osc_run;
  assign go_w = wr_ok && paddr == cise_pkg::CTRL_OFF && pwdata[cise_pkg::CTRL_GO_POS];
  assign wake_w = psel && penable && pwrite && pready && paddr == cise_pkg::CTRL_OFF && pwdata[cise_pkg::CTRL_WAKE_POS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 4'h0;
    end else if (wr_ok && paddr == cise_pkg::INSTR_OFF) begin
      op_q <= pwdata[cise_pkg::INSTR_OP_LSB +: 4];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  // ==========================================================
  property p_answer; psel && !penable |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_ctrl_rd; psel && !penable && !pwrite && paddr == cise_pkg::CTRL_OFF |=> prdata == 32'h0; endproperty
  property p_single; go_w && op_q != cise_pkg::OP_RETURN |=> busy ##1 !busy; endproperty
  property p_return; go_w && op_q == cise_pkg::OP_RETURN |=> busy [*2] ##1 !busy; endproperty
  property p_busy_cause; $rose(busy) |-> $past(go_w); endproperty
  property p_sleep; go_w && op_q == cise_pkg::OP_SLEEP |=> ##[1:2] !osc_run; endproperty
  property p_halt; !osc_run && !wake_w |=> !osc_run; endproperty
  property p_osc_kept; go_w && op_q != cise_pkg::OP_SLEEP |=> osc_run [*3]; endproperty
  a_answer: assert property (p_answer) else $error("no ready one cycle after setup");
  a_err: assert property (p_err) else $error("error flag without ready");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control register read not zero");
  a_single: assert property (p_single) else $error("busy not exactly one cycle");
  a_return: assert property (p_return) else $error("return busy not two cycles");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without go");
  a_sleep: assert property (p_sleep) else $error("oscillator still running after sleep");
  a_halt: assert property (p_halt) else $error("left halt without wake");
  a_osc_kept: assert property (p_osc_kept) else $error("oscillator stopped by other op");
  c_return: cover property (go_w && op_q == cise_pkg::OP_RETURN);
  c_halt: cover property (!osc_run);
  c_err: cover property (pslverr);
endmodule
bind cise_exec cise_exec_chk cise_exec_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_run(osc_run), .busy(busy));

// >>> verification/test_cise_exec.sv
// Self-checking testbench for the instruction subset executor.
`timescale 1ns/1ps
module test_cise_exec;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        osc_run;
  logic        busy;
  int          errors = 0;
  int          comparisons = 0;
  always #50 pclk = ~pclk;
  cise_exec cise_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_run(osc_run),
    .busy(busy));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle cycle so psel is never reassigned in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [7:0] a, r, input logic [4:0] f, input logic [3:0] op, input logic dst,
                     input logic [7:0] k, ea, er, input logic [4:0] ef);
    int n;
    int ecyc;
    apb(1'b1, cise_pkg::ACCUM_OFF, {24'h0, a});
    apb(1'b1, cise_pkg::REG_OFF, {24'h0, r});
    apb(1'b1, cise_pkg::STATUS_OFF, {27'h0, f});
    apb(1'b1, cise_pkg::INSTR_OFF, {16'h0, op, 3'h0, dst, k});
    apb(1'b1, cise_pkg::CTRL_OFF, 32'h1);
    n = 0;
    while (busy !== 1'b0 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    ecyc = (op == cise_pkg::OP_RETURN) ? int'(cise_pkg::RETURN_CYCLES) : int'(cise_pkg::SINGLE_CYCLES);
    check(n, ecyc);
    apb(1'b0, cise_pkg::ACCUM_OFF, 32'h0);
    check(rd, {24'h0, ea});
    apb(1'b0, cise_pkg::REG_OFF, 32'h0);
    check(rd, {24'h0, er});
    apb(1'b0, cise_pkg::STATUS_OFF, 32'h0);
    check({27'h0, rd[4:0]}, {27'h0, ef});
  endtask
  task automatic t_reset();
    apb(1'b0, cise_pkg::STATUS_OFF, 32'h0);
    check(rd, {27'h0, cise_pkg::FLAGS_RST});
    check({31'h0, err}, 32'h0);
    apb(1'b0, cise_pkg::PC_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic t_sub();
    run(8'h01, 8'h00, 5'h18, 4'h2, 1'b0, 8'h10, 8'h0f, 8'h00, 5'h19);
    run(8'h05, 8'h00, 5'h18, 4'h2, 1'b0, 8'h05, 8'h00, 8'h00, 5'h1f);
    run(8'h01, 8'h00, 5'h1f, 4'h2, 1'b0, 8'h00, 8'hff, 8'h00, 5'h18);
    run(8'h10, 8'h20, 5'h18, 4'h4, 1'b1, 8'h00, 8'h10, 8'h10, 5'h1b);
    run(8'h21, 8'h12, 5'h1b, 4'h4, 1'b0, 8'h00, 8'hf1, 8'h12, 5'h1a);
  endtask
  task automatic t_rot_nib();
    run(8'h00, 8'h02, 5'h1d, 4'h3, 1'b0, 8'h00, 8'h81, 8'h02, 5'h1c);
    run(8'h00, 8'h03, 5'h18, 4'h3, 1'b1, 8'h00, 8'h00, 8'h01, 5'h19);
    run(8'h33, 8'ha5, 5'h1b, 4'h5, 1'b1, 8'h00, 8'h33, 8'h5a, 5'h1b);
    run(8'h00, 8'hf0, 5'h18, 4'h5, 1'b0, 8'h00, 8'h0f, 8'hf0, 5'h18);
  endtask
  task automatic t_xor();
    run(8'hff, 8'hff, 5'h19, 4'h6, 1'b0, 8'h00, 8'h00, 8'hff, 5'h1d);
    run(8'h0f, 8'hf0, 5'h1c, 4'h6, 1'b1, 8'h00, 8'h0f, 8'hff, 5'h18);
    run(8'h0f, 8'h00, 5'h1c, 4'h7, 1'b0, 8'hf0, 8'hff, 8'h00, 5'h18);
    run(8'h0f, 8'h00, 5'h18, 4'h7, 1'b1, 8'h0f, 8'h00, 8'h00, 5'h1c);
  endtask
  task automatic t_return();
    apb(1'b1, cise_pkg::STACK_OFF, 32'h0123);
    run(8'h07, 8'h07, 5'h1b, 4'h1, 1'b0, 8'h00, 8'h07, 8'h07, 5'h1b);
    apb(1'b0, cise_pkg::PC_OFF, 32'h0);
    check(rd, 32'h0123);
  endtask
  task automatic t_sleep();
    run(8'h11, 8'h22, 5'h1f, 4'h0, 1'b0, 8'h00, 8'h11, 8'h22, 5'h17);
    apb(1'b0, cise_pkg::WDOG_OFF, 32'h0);
    check(rd, 32'h0);
    check({31'h0, osc_run}, 32'h0);
    apb(1'b1, cise_pkg::CTRL_OFF, 32'h2);
    check({31'h0, osc_run}, 32'h1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sub();
    t_rot_nib();
    t_xor();
    t_return();
    t_sleep();
    wrap_up();
  end
endmodule
